//--- rtl/pswg_core.sv
// Power stage waveform generator with Wishbone register slave
//
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module pswg_core
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic part_a_output_o,
	output logic part_b_output_o,
	output logic [3:0] output_matrix_o,
	output logic cycle_end_o
);
	logic [15:0] set_a_reg, rst_a_reg, set_b_reg, rst_b_reg;
	logic [7:0] cfg_reg, ocfg_reg, omtx_reg;
	logic run_reg;
	logic [11:0] set_a_act, rst_a_act, set_b_act, rst_b_act;
	logic [3:0] div_act;
	logic [7:0] ocfg_act;
	logic [3:0] omtx_act;
	logic auto_act;
	logic last_rb_reg;
	logic [11:0] cnt_reg;
	logic [11:0] cnt_next;
	logic up_reg;
	logic extra_reg;
	logic out_a_reg, out_b_reg;
	logic end_reg;
	logic restart;
	logic cycle_end;
	logic load;
	logic long_cycle;
	logic [1:0] mode;
	pswg_pkg::pswg_state_t st_reg;

	wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wb_wr = wb_req && wb_we_i;
	wire [3:0] idx = wb_adr_i[5:2];

	function automatic logic [15:0] pswg_merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		pswg_merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_req;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			wb_dat_o <= 32'h0000_0000;
		else if (wb_req && !wb_we_i)
		begin
			case (idx)
				pswg_pkg::PSWG_ADR_SET_A: wb_dat_o <= {16'h0000, set_a_reg};
				pswg_pkg::PSWG_ADR_RST_A: wb_dat_o <= {16'h0000, rst_a_reg};
				pswg_pkg::PSWG_ADR_SET_B: wb_dat_o <= {16'h0000, set_b_reg};
				pswg_pkg::PSWG_ADR_RST_B: wb_dat_o <= {16'h0000, rst_b_reg};
				pswg_pkg::PSWG_ADR_CFG: wb_dat_o <= {24'h000000, cfg_reg};
				pswg_pkg::PSWG_ADR_CTL: wb_dat_o <= {31'h0000_0000, run_reg};
				pswg_pkg::PSWG_ADR_OCFG: wb_dat_o <= {24'h000000, ocfg_reg};
				pswg_pkg::PSWG_ADR_OMTX: wb_dat_o <= {24'h000000, omtx_reg};
				pswg_pkg::PSWG_ADR_STAT: wb_dat_o <= {16'h0000, st_reg, cnt_reg};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// Buffered compare registers written by software
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			set_a_reg <= pswg_pkg::PSWG_CMP_RST;
			rst_a_reg <= pswg_pkg::PSWG_CMP_RST;
			set_b_reg <= pswg_pkg::PSWG_CMP_RST;
			rst_b_reg <= pswg_pkg::PSWG_CMP_RST;
			cfg_reg <= pswg_pkg::PSWG_CFG_RST;
			ocfg_reg <= pswg_pkg::PSWG_CFG_RST;
			omtx_reg <= pswg_pkg::PSWG_CFG_RST;
		end
		else if (wb_wr)
		begin
			case (idx)
				pswg_pkg::PSWG_ADR_SET_A: set_a_reg <= pswg_merge(set_a_reg, wb_dat_i, wb_sel_i);
				pswg_pkg::PSWG_ADR_RST_A: rst_a_reg <= pswg_merge(rst_a_reg, wb_dat_i, wb_sel_i);
				pswg_pkg::PSWG_ADR_SET_B: set_b_reg <= pswg_merge(set_b_reg, wb_dat_i, wb_sel_i);
				pswg_pkg::PSWG_ADR_RST_B: rst_b_reg <= pswg_merge(rst_b_reg, wb_dat_i, wb_sel_i);
				pswg_pkg::PSWG_ADR_CFG: if (wb_sel_i[0]) cfg_reg <= wb_dat_i[7:0];
				pswg_pkg::PSWG_ADR_OCFG: if (wb_sel_i[0]) ocfg_reg <= wb_dat_i[7:0];
				pswg_pkg::PSWG_ADR_OMTX: if (wb_sel_i[0]) omtx_reg <= wb_dat_i[7:0];
				default: ;
			endcase
		end
	end

	assign restart = wb_wr && idx == pswg_pkg::PSWG_ADR_CTL && wb_sel_i[0]
		&& wb_dat_i[pswg_pkg::PSWG_CTL_RESTART];

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			run_reg <= 1'b0;
		else if (wb_wr && idx == pswg_pkg::PSWG_ADR_CTL && wb_sel_i[0])
			run_reg <= wb_dat_i[pswg_pkg::PSWG_CTL_RUN];
	end

	// Tracks whether part B reset compare was the last compare written since the last transfer
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			last_rb_reg <= 1'b0;
		else if (wb_wr && idx == pswg_pkg::PSWG_ADR_RST_B)
			last_rb_reg <= 1'b1;
		else if (wb_wr && idx <= pswg_pkg::PSWG_ADR_SET_B)
			last_rb_reg <= 1'b0;
		else if (load)
			last_rb_reg <= 1'b0;
	end

	// Auto-update setting becomes effective only at a cycle end
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			auto_act <= 1'b0;
		else if (cycle_end)
			auto_act <= cfg_reg[pswg_pkg::PSWG_CFG_AUTO];
	end

	// Auto-update prevails; else hold blocks; a stopped block loads freely
	assign load = !run_reg || restart || (cycle_end && (auto_act ? last_rb_reg
		: !cfg_reg[pswg_pkg::PSWG_CFG_HOLD]));

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			set_a_act <= 12'h000;
			rst_a_act <= 12'h000;
			set_b_act <= 12'h000;
			rst_b_act <= 12'h000;
			div_act <= 4'h0;
			ocfg_act <= pswg_pkg::PSWG_CFG_RST;
			omtx_act <= 4'h0;
			mode <= pswg_pkg::PSWG_MODE_FOUR;
		end
		else if (load)
		begin
			// Fifty-percent mode duplicates part B into part A
			set_a_act <= cfg_reg[pswg_pkg::PSWG_CFG_FIFTY] ? set_b_reg[11:0]
				: set_a_reg[11:0];
			rst_a_act <= cfg_reg[pswg_pkg::PSWG_CFG_FIFTY] ? rst_b_reg[11:0]
				: rst_a_reg[11:0];
			set_b_act <= set_b_reg[11:0];
			rst_b_act <= rst_b_reg[11:0];
			div_act <= rst_b_reg[15:12];
			ocfg_act <= ocfg_reg;
			omtx_act <= omtx_reg[3:0];
			mode <= cfg_reg[1:0];
		end
	end

	pswg_frame u_frame
	(
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.cycle_end_i(cycle_end),
		.enh_i(cfg_reg[pswg_pkg::PSWG_CFG_ENH]),
		.divider_i(div_act),
		.long_o(long_cycle)
	);

	// Cycle end: last count of part B (in center mode the count back at zero after the down ramp)
	always_comb
	begin
		cycle_end = 1'b0;
		case (mode)
			pswg_pkg::PSWG_MODE_FOUR:
				cycle_end = st_reg == pswg_pkg::PSWG_ST_ON_B && cnt_reg + 12'h001 >= rst_b_act;
			pswg_pkg::PSWG_MODE_TWO:
				cycle_end = st_reg == pswg_pkg::PSWG_ST_DEAD_B && cnt_reg >= rst_b_act;
			pswg_pkg::PSWG_MODE_ONE:
				cycle_end = cnt_reg >= rst_b_act;
			pswg_pkg::PSWG_MODE_CENTER:
				cycle_end = !up_reg && cnt_reg == 12'h000;
			default: cycle_end = 1'b0;
		endcase
		// Extra count of a long cycle sits in part A, so it must not mask the end
		cycle_end = cycle_end && run_reg;
	end

	// Counter and phase sequencing
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i || restart || !run_reg || cycle_end)
		begin
			cnt_reg <= 12'h000;
			st_reg <= pswg_pkg::PSWG_ST_DEAD_A;
			up_reg <= 1'b1;
			extra_reg <= 1'b0;
		end
		else
		begin
			case (mode)
				pswg_pkg::PSWG_MODE_FOUR:
				begin
					cnt_reg <= cnt_reg + 12'h001;
					case (st_reg)
						pswg_pkg::PSWG_ST_DEAD_A:
							if (cnt_reg + 12'h001 >= set_a_act + pswg_pkg::PSWG_DEAD4_EXTRA)
							begin
								cnt_reg <= 12'h000;
								st_reg <= pswg_pkg::PSWG_ST_ON_A;
							end
						pswg_pkg::PSWG_ST_ON_A:
							if (cnt_reg + 12'h001 >= rst_a_act && !(long_cycle && !extra_reg))
							begin
								cnt_reg <= 12'h000;
								st_reg <= pswg_pkg::PSWG_ST_DEAD_B;
							end
							else if (cnt_reg + 12'h001 >= rst_a_act)
							begin
								cnt_reg <= cnt_reg;
								extra_reg <= 1'b1;
							end
						pswg_pkg::PSWG_ST_DEAD_B:
							if (cnt_reg + 12'h001 >= set_b_act + pswg_pkg::PSWG_DEAD4_EXTRA)
							begin
								cnt_reg <= 12'h000;
								st_reg <= pswg_pkg::PSWG_ST_ON_B;
							end
						default: ;
					endcase
				end
				pswg_pkg::PSWG_MODE_TWO:
				begin
					cnt_reg <= cnt_reg + 12'h001;
					if (st_reg == pswg_pkg::PSWG_ST_DEAD_A && cnt_reg >= rst_a_act)
					begin
						if (long_cycle && !extra_reg)
						begin
							cnt_reg <= cnt_reg;
							extra_reg <= 1'b1;
						end
						else
						begin
							cnt_reg <= 12'h000;
							st_reg <= pswg_pkg::PSWG_ST_DEAD_B;
						end
					end
				end
				pswg_pkg::PSWG_MODE_CENTER:
				begin
					if (up_reg && cnt_reg >= rst_b_act)
						up_reg <= 1'b0;
					else
						cnt_reg <= up_reg ? cnt_reg + 12'h001 : cnt_reg - 12'h001;
				end
				default:
				begin
					if (long_cycle && !extra_reg && cnt_reg == 12'h000)
						extra_reg <= 1'b1;
					else
						cnt_reg <= cnt_reg + 12'h001;
				end
			endcase
		end
	end

	// Output shaping from counter position
	always_comb
	begin
		out_a_reg = 1'b0;
		out_b_reg = 1'b0;
		case (mode)
			pswg_pkg::PSWG_MODE_FOUR:
			begin
				out_a_reg = st_reg == pswg_pkg::PSWG_ST_ON_A;
				out_b_reg = st_reg == pswg_pkg::PSWG_ST_ON_B;
			end
			pswg_pkg::PSWG_MODE_TWO:
			begin
				out_a_reg = st_reg == pswg_pkg::PSWG_ST_DEAD_A && cnt_reg > set_a_act;
				out_b_reg = st_reg == pswg_pkg::PSWG_ST_DEAD_B && cnt_reg > set_b_act;
			end
			pswg_pkg::PSWG_MODE_ONE:
			begin
				out_a_reg = cnt_reg > set_a_act && cnt_reg <= rst_a_act;
				out_b_reg = cnt_reg > set_b_act && cnt_reg <= rst_b_act;
			end
			pswg_pkg::PSWG_MODE_CENTER:
			begin
				out_a_reg = cnt_reg < set_a_act;
				out_b_reg = cnt_reg >= set_b_act;
			end
			default: ;
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			part_a_output_o <= 1'b0;
			part_b_output_o <= 1'b0;
			output_matrix_o <= 4'h0;
			cycle_end_o <= 1'b0;
			end_reg <= 1'b0;
		end
		else
		begin
			part_a_output_o <= run_reg && ocfg_act[pswg_pkg::PSWG_OCFG_EN0]
				&& (out_a_reg ^ ocfg_act[pswg_pkg::PSWG_OCFG_POL]);
			part_b_output_o <= run_reg && ocfg_act[pswg_pkg::PSWG_OCFG_EN1]
				&& (out_b_reg ^ ocfg_act[pswg_pkg::PSWG_OCFG_POL]);
			output_matrix_o <= omtx_act;
			cycle_end_o <= cycle_end;
			end_reg <= cycle_end;
		end
	end

	wb_ack_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not acknowledged next cycle");
	hold_block_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		run_reg && !restart && !cycle_end |-> !load)
		else $error("transfer away from cycle end");
	hold_bit_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		cycle_end && run_reg && !restart && !auto_act && cfg_reg[pswg_pkg::PSWG_CFG_HOLD]
		|-> !load) else $error("transfer while hold set");
	auto_last_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		cycle_end && run_reg && !restart && auto_act |-> load == last_rb_reg)
		else $error("auto transfer ignores last write");
	auto_late_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!cycle_end |=> auto_act == $past(auto_act))
		else $error("auto setting changed mid cycle");
	fifty_copy_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		load && cfg_reg[pswg_pkg::PSWG_CFG_FIFTY] |=> set_a_act == set_b_act
		&& rst_a_act == rst_b_act) else $error("fifty copy missing");
	cycle_restart_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		cycle_end |=> cnt_reg == 12'h000 && st_reg == pswg_pkg::PSWG_ST_DEAD_A)
		else $error("cycle did not restart at part A");
	four_out_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		mode == pswg_pkg::PSWG_MODE_FOUR && st_reg == pswg_pkg::PSWG_ST_DEAD_A |-> !out_a_reg)
		else $error("output 0 active in dead time");
	end_cv: cover property (@(posedge sys_clk_i) end_reg);
	center_cv: cover property (@(posedge sys_clk_i)
		mode == pswg_pkg::PSWG_MODE_CENTER && cycle_end);
	long_cv: cover property (@(posedge sys_clk_i) extra_reg);
endmodule

//--- common/pswg_pkg.sv
// Constants for the power stage waveform generator
package pswg_pkg;
	localparam logic [3:0] PSWG_ADR_SET_A = 4'h0;
	localparam logic [3:0] PSWG_ADR_RST_A = 4'h1;
	localparam logic [3:0] PSWG_ADR_SET_B = 4'h2;
	localparam logic [3:0] PSWG_ADR_RST_B = 4'h3;
	localparam logic [3:0] PSWG_ADR_CFG = 4'h4;
	localparam logic [3:0] PSWG_ADR_CTL = 4'h5;
	localparam logic [3:0] PSWG_ADR_OCFG = 4'h6;
	localparam logic [3:0] PSWG_ADR_OMTX = 4'h7;
	localparam logic [3:0] PSWG_ADR_STAT = 4'h8;
	localparam int PSWG_CFG_MODE_LSB = 0;
	localparam int PSWG_CFG_FIFTY = 2;
	localparam int PSWG_CFG_ENH = 3;
	localparam int PSWG_CFG_HOLD = 4;
	localparam int PSWG_CFG_AUTO = 5;
	localparam int PSWG_CTL_RUN = 0;
	localparam int PSWG_CTL_RESTART = 1;
	localparam int PSWG_OCFG_EN0 = 0;
	localparam int PSWG_OCFG_EN1 = 1;
	localparam int PSWG_OCFG_POL = 2;
	localparam logic [1:0] PSWG_MODE_FOUR = 2'h0;
	localparam logic [1:0] PSWG_MODE_TWO = 2'h1;
	localparam logic [1:0] PSWG_MODE_ONE = 2'h2;
	localparam logic [1:0] PSWG_MODE_CENTER = 2'h3;
	localparam logic [11:0] PSWG_DEAD4_EXTRA = 12'h002;
	localparam logic [11:0] PSWG_DEAD2_EXTRA = 12'h001;
	localparam logic [15:0] PSWG_CMP_RST = 16'h0000;
	localparam logic [7:0] PSWG_CFG_RST = 8'h00;
	localparam logic [3:0] PSWG_FRAME_LAST = 4'hF;
	typedef enum logic [3:0]
	{
		PSWG_ST_DEAD_A = 4'h1,
		PSWG_ST_ON_A = 4'h2,
		PSWG_ST_DEAD_B = 4'h4,
		PSWG_ST_ON_B = 4'h8
	} pswg_state_t;
endpackage

//--- rtl/pswg_frame.sv
// Enhanced-resolution frame counter and long-cycle selector
`timescale 1ns/1ps
module pswg_frame
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic cycle_end_i,
	input wire logic enh_i,
	input wire logic [3:0] divider_i,
	output logic long_o
);
	logic [3:0] idx_reg;

	function automatic logic [3:0] pswg_rev4(input logic [3:0] v);
		pswg_rev4 = {v[0], v[1], v[2], v[3]};
	endfunction

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i || !enh_i)
			idx_reg <= 4'h0;
		else if (cycle_end_i)
			idx_reg <= idx_reg + 4'h1;
	end

	// Order 0,8,4,12,... equals bit-reversed index below d
	assign long_o = enh_i && (pswg_rev4(idx_reg) < divider_i);

	frame_wrap_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		enh_i && cycle_end_i && idx_reg == pswg_pkg::PSWG_FRAME_LAST |=> idx_reg == 4'h0)
		else $error("frame did not wrap after 16 cycles");
	zero_div_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		divider_i == 4'h0 |-> !long_o)
		else $error("long cycle with zero divider");
endmodule

//--- sim/pswg_load_model.sv
// Load model: measures cycle length and output high times per cycle
`timescale 1ns/1ps
module pswg_load_model
(
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic out_a_i,
	input wire logic out_b_i,
	input wire logic cycle_end_i,
	output int period_o,
	output int on_a_o,
	output int on_b_o,
	output logic done_o
);
	int cnt_reg;
	int ha_reg;
	int hb_reg;
	always_ff @(posedge sys_clk_i)
	begin
		done_o <= cycle_end_i & ~rst_i;
		cnt_reg <= (rst_i || cycle_end_i) ? 0 : cnt_reg + 1;
		ha_reg <= (rst_i || cycle_end_i) ? 0 : ha_reg + int'(out_a_i);
		hb_reg <= (rst_i || cycle_end_i) ? 0 : hb_reg + int'(out_b_i);
		if (cycle_end_i)
		begin
			period_o <= cnt_reg + 1;
			on_a_o <= ha_reg + int'(out_a_i);
			on_b_o <= hb_reg + int'(out_b_i);
		end
	end
endmodule

//--- sim/tb_power_stage_waveform_generator.sv
// Self-checking bench for the power stage waveform generator
`timescale 1ns/1ps
module tb_power_stage_waveform_generator;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [5:0] wb_adr_i = 6'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic part_a_output_o;
	logic part_b_output_o;
	logic [3:0] output_matrix_o;
	logic cycle_end_o;
	logic done;
	logic [31:0] q;
	int period;
	int on_a;
	int on_b;
	int errors = 0;
	int checks = 0;
	int cycles = 0;
	integer seed = 32'hEC5C;
	int sa, ra, sb, rb, d, n, k;
	always #2.5 sys_clk_i = ~sys_clk_i;
	pswg_core pswg_core_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.part_a_output_o(part_a_output_o), .part_b_output_o(part_b_output_o),
		.output_matrix_o(output_matrix_o), .cycle_end_o(cycle_end_o));
	pswg_load_model pswg_load_model_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.out_a_i(part_a_output_o), .out_b_i(part_b_output_o), .cycle_end_i(cycle_end_o),
		.period_o(period), .on_a_o(on_a), .on_b_o(on_b), .done_o(done));
	task end_of_test;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge sys_clk_i)
	begin
		cycles = cycles + 1;
		if (cycles == 60000)
		begin
			errors = errors + 1;
			end_of_test();
		end
	end
	task chk(input logic [31:0] exp, input logic [31:0] got);
		checks = checks + 1;
		if (exp !== got)
		begin
			errors = errors + 1;
			$display("wrong value at %0t: expected %h got %h", $time, exp, got);
		end
	endtask
	// Classic single Wishbone cycle; ack and read data are taken at a rising edge
	task wb(input logic we, input logic [3:0] idx, input int dat);
		@(posedge sys_clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= 4'hF;
		wb_dat_i <= dat;
		@(posedge sys_clk_i);
		while (wb_ack_o !== 1'b1) @(posedge sys_clk_i);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task waitp(input int c);
		repeat (c) @(posedge sys_clk_i iff done === 1'b1);
	endtask
	task meas(input int ep, input int ea, input int eb);
		chk(ep, period);
		chk(ea, on_a);
		chk(eb, on_b);
	endtask
	// Stopped block takes buffers directly, then runs
	task setup(input logic [7:0] cfg);
		wb(1'b1, pswg_pkg::PSWG_ADR_CTL, 0);
		wb(1'b1, pswg_pkg::PSWG_ADR_SET_A, sa);
		wb(1'b1, pswg_pkg::PSWG_ADR_RST_A, ra);
		wb(1'b1, pswg_pkg::PSWG_ADR_SET_B, sb);
		wb(1'b1, pswg_pkg::PSWG_ADR_RST_B, rb);
		wb(1'b1, pswg_pkg::PSWG_ADR_CFG, cfg);
		wb(1'b1, pswg_pkg::PSWG_ADR_OCFG, 3);
		wb(1'b1, pswg_pkg::PSWG_ADR_CTL, 1);
		waitp(3);
	endtask
	function automatic int rnd();
		rnd = ($random(seed) & 31) + 1;
	endfunction
	function automatic int p4();
		p4 = sa + ra + sb + rb + 4;
	endfunction
	initial
	begin
		repeat (3) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		for (int m = 0; m < 4; m++)
		begin
			sa = rnd();
			ra = rnd();
			sb = rnd();
			rb = rnd();
			if (m != 0) ra = sa + ra;
			if (m >= 2) sb = ((m == 2) ? ra : sa) + sb;
			if (m != 0) rb = sb + rb;
			setup({6'h00, 2'(m)});
			k = (m == 0) ? p4() : (m == 1) ? ra + rb + 2 : (m == 2) ? rb + 1 : 2 * (rb + 1);
			d = (m == 0) ? rb : (m == 3) ? 2 * (rb - sb + 1) : rb - sb;
			meas(k, (m == 0) ? ra : (m == 3) ? 2 * sa : ra - sa, d);
		end
		$display("test modes done");
		sa = rnd();
		ra = rnd();
		sb = rnd();
		rb = rnd();
		setup(8'h04);
		meas(2 * (sb + rb + 2), rb, rb);
		$display("test fifty done");
		d = rnd() % 15 + 1;
		rb = rnd();
		k = p4();
		rb = rb + (d << 12);
		setup(8'h08);
		n = 0;
		repeat (16)
		begin
			waitp(1);
			if (period == k + 1)
				n = n + 1;
			else
				chk(k, period);
		end
		chk(d, n);
		$display("test enhanced done");
		rb = rnd();
		setup(8'h00);
		k = rnd();
		wb(1'b1, pswg_pkg::PSWG_ADR_CFG, 8'h10);
		wb(1'b1, pswg_pkg::PSWG_ADR_RST_B, k);
		wb(1'b1, pswg_pkg::PSWG_ADR_OCFG, 1);
		wb(1'b1, pswg_pkg::PSWG_ADR_OMTX, 4'hA);
		waitp(3);
		meas(p4(), ra, rb);
		chk(0, output_matrix_o);
		rb = k;
		wb(1'b1, pswg_pkg::PSWG_ADR_CFG, 8'h00);
		waitp(3);
		meas(p4(), ra, 0);
		chk(4'hA, output_matrix_o);
		$display("test hold done");
		wb(1'b1, pswg_pkg::PSWG_ADR_OCFG, 3);
		// Output config must be active before auto-update arms
		waitp(2);
		wb(1'b1, pswg_pkg::PSWG_ADR_CFG, 8'h30);
		waitp(2);
		n = rnd();
		k = rnd();
		wb(1'b1, pswg_pkg::PSWG_ADR_RST_B, n);
		wb(1'b1, pswg_pkg::PSWG_ADR_SET_A, k);
		waitp(3);
		meas(p4(), ra, rb);
		wb(1'b1, pswg_pkg::PSWG_ADR_RST_B, n);
		sa = k;
		rb = n;
		waitp(3);
		meas(p4(), ra, rb);
		$display("test auto done");
		wb(1'b1, pswg_pkg::PSWG_ADR_CFG, 8'h10);
		ra = rnd();
		wb(1'b1, pswg_pkg::PSWG_ADR_RST_A, ra);
		wb(1'b1, pswg_pkg::PSWG_ADR_CTL, 3);
		waitp(2);
		meas(p4(), ra, rb);
		wb(1'b0, pswg_pkg::PSWG_ADR_SET_A, 0);
		chk(sa, q);
		wb(1'b1, 4'hC, 32'h0000FFFF);
		wb(1'b0, 4'hC, 0);
		chk(0, q);
		$display("test restart and registers done");
		end_of_test();
	end
endmodule
